//--- rtl/dmo_pkg.sv
// Constants and types shared by both ends of the DRAM mode-option link.
// Assumes one 40 MHz clock (mclk_i) and a synchronous active-high reset.
`default_nettype none

package dmo_pkg;
  // Clock period in picoseconds (40 MHz)
  localparam int unsigned CLK_PS         = 25000;
  // Clear-timer hold time, least
  localparam int unsigned CLR_HOLD_NS    = 500;
  localparam int unsigned CLR_HOLD_CYC   = (CLR_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Hardware reset hold, in clock edges
  localparam int unsigned HW_RST_EDGES   = 16;
  // Refresh interval span, in microseconds
  localparam int unsigned EXTERNAL_REFRESH_IN_MIN_US    = 13;
  localparam int unsigned EXTERNAL_REFRESH_IN_MAX_US    = 15;
  localparam int unsigned EXTERNAL_REFRESH_IN_MIN_CYC   = EXTERNAL_REFRESH_IN_MIN_US * 1000000 / CLK_PS;
  localparam int unsigned EXTERNAL_REFRESH_IN_STEP_CYC  = (EXTERNAL_REFRESH_IN_MAX_US - EXTERNAL_REFRESH_IN_MIN_US) * 1000000 / CLK_PS / 15;
  // Width of refresh-rate field
  localparam int unsigned RATE_W         = 4;
  // Mode word layout (loaded on mode-load strobe)
  localparam int unsigned MODE_W         = 8;
  localparam int unsigned MB_ROW_DLY     = 0;  // Row-delay select bit
  localparam int unsigned MB_PIPE        = 1;  // Address pipelining mode
  localparam int unsigned MB_RATE        = 2;  // Refresh-rate bits [5:2]
  localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
  // Host command register map
  localparam logic [3:0] A_CTRL  = 4'h0;  // Bit0 start reset, bit1 program
  localparam logic [3:0] A_MODE  = 4'h4;  // Mode word to program
  localparam logic [3:0] A_DRIVE = 4'h8;  // Bit0 access, 1 ext0, 2 ext1, 3 grant, 4 clr
  localparam logic [3:0] A_STAT  = 4'hc;  // Bit0 busy, 1 col strobe, 2 row, 3 we pin
  localparam int unsigned DW     = 8;
  typedef enum logic [1:0] {ROW_IDLE, ROW_WAIT, ROW_ON} dmo_row_t;
endpackage

`default_nettype wire

//--- rtl/dmo_link_if.sv
// Pin-level link between the controller end and the host end.
// Assumes both ends clock on mclk_i.
`default_nettype none

interface dmo_link_if;
  logic                          mode_load_strobe;
  logic                          refresh_disable_in;
  logic                          external_refresh_in;
  logic                          access_request;       // Active high here
  logic [1:0]                    extend_col_strobe_in; // [0] is the first one
  logic                          column_increment_in;  // Active high
  logic                          port_b_grant;
  logic [dmo_pkg::MODE_W-1:0]    mode_addr;            // Mode word on address bus
  logic                          col_strobe;
  logic                          row_strobe;
  logic                          write_enable_pin;
  modport dev  (input mode_load_strobe, refresh_disable_in, external_refresh_in,
                access_request, extend_col_strobe_in, column_increment_in,
                port_b_grant, mode_addr,
                output col_strobe, row_strobe, write_enable_pin);
  modport host (output mode_load_strobe, refresh_disable_in, external_refresh_in,
                access_request, extend_col_strobe_in, column_increment_in,
                port_b_grant, mode_addr,
                input col_strobe, row_strobe, write_enable_pin);
endinterface

`default_nettype wire

//--- rtl/dmo_dev.sv
// Controller end: mode latch, strobe extension, row delay, refresh timer.
// Assumes link inputs are synchronous to mclk_i.
//
// Design decisions made here: the address map and the plain strobed port.
`default_nettype none

module dmo_dev (
  input  wire logic mclk_i,
  input  wire logic srst_i,
  dmo_link_if.dev   lnk,
  output logic      refresh_request_o,   // Internal refresh request pulse
  output logic      in_reset_o           // Hardware reset held
);
  import dmo_pkg::*;

  logic [MODE_W-1:0] mode_q;        // Programmed mode word
  logic [1:0]        ext_neg_q;     // Extend inputs negated during load
  logic [4:0]        hrst_cnt_q;    // Hardware reset edge count
  logic [15:0]       clr_cnt_q;     // Clear-condition duration
  logic [19:0]       rf_cnt_q;      // Refresh interval timer
  logic              col_q, row_q, we_q, refresh_request_out_q, inrst_q, gnt_q;
  dmo_row_t          rst_q;

  wire hw_rst    = lnk.mode_load_strobe & lnk.refresh_disable_in;
  wire clr_cond  = ~lnk.refresh_disable_in & lnk.external_refresh_in;
  wire [19:0] rf_lim = 20'(EXTERNAL_REFRESH_IN_MIN_CYC) +
                       20'(mode_q[MB_RATE +: RATE_W]) * 20'(EXTERNAL_REFRESH_IN_STEP_CYC);
  wire gnt_chg   = lnk.port_b_grant != gnt_q;

  //////////////////////////////////////////////////////////////////////////
  // Mode load and hardware reset
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mode_q     <= MODE_RST;
      ext_neg_q  <= 2'h0;
      hrst_cnt_q <= 5'h00;
      inrst_q    <= 1'b0;
    end else if (hw_rst) begin
      // Reset only takes effect after the full edge count
      if (hrst_cnt_q < 5'(HW_RST_EDGES)) hrst_cnt_q <= hrst_cnt_q + 5'h01;
      else begin
        // Forget extend choices too, so no stale extension survives reset
        mode_q    <= MODE_RST;
        ext_neg_q <= 2'h0;
        inrst_q   <= 1'b1;
      end
    end else begin
      hrst_cnt_q <= 5'h00;
      inrst_q    <= 1'b0;
      if (lnk.mode_load_strobe) begin
        mode_q    <= lnk.mode_addr;
        ext_neg_q <= ~lnk.extend_col_strobe_in;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // column strobe extension
  always_ff @(posedge mclk_i) begin
    if (srst_i) col_q <= 1'b0;
    else col_q <= lnk.access_request |
                  (|(ext_neg_q & lnk.extend_col_strobe_in) & col_q);
  end

  //////////////////////////////////////////////////////////////////////////
  // row strobe delay after grant change
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rst_q <= ROW_IDLE; row_q <= 1'b0; gnt_q <= 1'b0;
    end else begin
      gnt_q <= lnk.port_b_grant;
      case (rst_q)
        // Strobe lands one clock after the change, or two with the delay bit
        ROW_IDLE: if (gnt_chg) begin
          if (mode_q[MB_ROW_DLY]) rst_q <= ROW_WAIT;
          else begin
            rst_q <= ROW_ON; row_q <= 1'b1;
          end
        end
        ROW_WAIT: begin
          rst_q <= ROW_ON; row_q <= 1'b1;
        end
        ROW_ON: if (!lnk.access_request) begin
          rst_q <= ROW_IDLE; row_q <= 1'b0;
        end
        default: rst_q <= ROW_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // refresh timer clear and request generation
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      clr_cnt_q <= 16'h0000; rf_cnt_q <= 20'h00000; refresh_request_out_q <= 1'b0;
    end else begin
      clr_cnt_q <= clr_cond ? ((clr_cnt_q < 16'(CLR_HOLD_CYC)) ? clr_cnt_q + 16'h0001
                                                              : clr_cnt_q) : 16'h0000;
      refresh_request_out_q <= 1'b0;
      if (clr_cnt_q >= 16'(CLR_HOLD_CYC) || inrst_q) rf_cnt_q <= 20'h00000;
      else if (rf_cnt_q >= rf_lim) begin
        rf_cnt_q <= 20'h00000; refresh_request_out_q <= ~lnk.refresh_disable_in;
      end else rf_cnt_q <= rf_cnt_q + 20'h00001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write-enable pin carries refresh request
  always_ff @(posedge mclk_i) begin
    if (srst_i) we_q <= 1'b0;
    else we_q <= (ext_neg_q[0] | mode_q[MB_PIPE]) & refresh_request_out_q;
  end

  assign lnk.col_strobe       = col_q;
  assign lnk.row_strobe       = row_q;
  assign lnk.write_enable_pin = we_q;
  assign refresh_request_o    = refresh_request_out_q;
  assign in_reset_o           = inrst_q;
endmodule

`default_nettype wire

//--- rtl/dmo_host.sv
// Host end: performs the hardware reset, programs the mode, drives access pins.
// Assumes a simple register port from software, read data one cycle later.
`default_nettype none

module dmo_host (
  input  wire logic                 mclk_i,
  input  wire logic                 srst_i,
  dmo_link_if.host                  lnk,
  input  wire logic [3:0]           addr_i,
  input  wire logic [dmo_pkg::DW-1:0] wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic [dmo_pkg::DW-1:0]    rdata_o
);
  import dmo_pkg::*;

  logic [DW-1:0] mode_q, drv_q, rdata_q;
  logic [4:0]    cnt_q;
  logic          rst_busy_q, prog_q, ml_q, dis_q, clr_q;
  logic [15:0]   clr_cnt_q;

  wire wr_ctrl = wr_i & (addr_i == A_CTRL);
  wire [DW-1:0] stat = {4'h0, lnk.write_enable_pin, lnk.row_strobe,
                        lnk.col_strobe, rst_busy_q | prog_q | clr_q};

  //////////////////////////////////////////////////////////////////////////
  // Register writes and reset/program sequencing
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mode_q <= MODE_RST; drv_q <= 8'h00; cnt_q <= 5'h00;
      rst_busy_q <= 1'b0; prog_q <= 1'b0; ml_q <= 1'b0; dis_q <= 1'b0;
      clr_q <= 1'b0; clr_cnt_q <= 16'h0000;
    end else begin
      if (wr_i && addr_i == A_MODE) mode_q <= wdata_i;
      if (wr_i && addr_i == A_DRIVE) drv_q <= wdata_i;
      // hold both strobes for 17 edges (count 0 to HW_RST_EDGES, then release)
      if (wr_ctrl && wdata_i[0]) begin
        rst_busy_q <= 1'b1; ml_q <= 1'b1; dis_q <= 1'b1; cnt_q <= 5'h00;
      end else if (rst_busy_q) begin
        if (cnt_q == 5'(HW_RST_EDGES)) begin
          rst_busy_q <= 1'b0; ml_q <= 1'b0; dis_q <= 1'b0;
        end else cnt_q <= cnt_q + 5'h01;
      end else if (wr_ctrl && wdata_i[1]) begin
        prog_q <= 1'b1; ml_q <= 1'b1;
      end else if (prog_q) begin
        prog_q <= 1'b0; ml_q <= 1'b0;
      end
      if (wr_i && addr_i == A_DRIVE && wdata_i[4]) begin
        clr_q <= 1'b1; clr_cnt_q <= 16'h0000;
      end else if (clr_q) begin
        if (clr_cnt_q == 16'(CLR_HOLD_CYC)) clr_q <= 1'b0;
        else clr_cnt_q <= clr_cnt_q + 16'h0001;
      end
    end
  end

  // Read data one cycle after read strobe
  always_ff @(posedge mclk_i) begin
    if (srst_i) rdata_q <= 8'h00;
    else if (rd_i) rdata_q <= (addr_i == A_STAT) ? stat :
                              (addr_i == A_MODE) ? mode_q :
                              (addr_i == A_DRIVE) ? drv_q : 8'h00;
    else rdata_q <= 8'h00;
  end

  assign lnk.mode_load_strobe     = ml_q;
  assign lnk.refresh_disable_in   = dis_q;
  assign lnk.external_refresh_in  = clr_q;
  assign lnk.access_request       = drv_q[0];
  // extend inputs set by software at programming
  assign lnk.extend_col_strobe_in = drv_q[2:1];
  assign lnk.column_increment_in  = 1'b0;
  assign lnk.port_b_grant         = drv_q[3];
  assign lnk.mode_addr            = mode_q;
  assign rdata_o                  = rdata_q;
endmodule

`default_nettype wire

//--- bench/dmo_monitor.sv
// Checker on the link pins between the host end and the controller end.
// Assumes it sits beside the link instance, clocked by mclk_i.
`default_nettype none
module dmo_monitor import dmo_pkg::*; (
  input wire logic              mclk_i,
  input wire logic              srst_i,
  input wire logic              mode_load_strobe,
  input wire logic              refresh_disable_in,
  input wire logic              external_refresh_in,
  input wire logic              access_request,
  input wire logic [1:0]        extend_col_strobe_in,
  input wire logic              port_b_grant,
  input wire logic [MODE_W-1:0] mode_addr,
  input wire logic              col_strobe,
  input wire logic              row_strobe,
  input wire logic              write_enable_pin
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  wire        hw  = mode_load_strobe & refresh_disable_in;   // Hardware reset held
  wire        ld  = mode_load_strobe & ~refresh_disable_in;  // Mode word load
  wire        clr = external_refresh_in & ~refresh_disable_in;
  logic       ext_en_q, we_en_q, rdly_q;                     // Copy of loaded mode
  logic [4:0] hw_q;
  logic [5:0] clr_q;
  logic [9:0] gap_q;  // Saturates: a pulse long after a clear never trips
  wire        clr_hit = clr && (clr_q == 6'(CLR_HOLD_CYC - 1));
  sequence grant_go;
    $changed(port_b_grant) && $rose(access_request);
  endsequence
  ////////////////////////////////////////////////////////////////
  // Counters and mode copy; a hardware reset clears the mode
  always_ff @(posedge mclk_i) begin
    hw_q  <= (srst_i | ~hw) ? 5'h00 : hw_q + {4'h0, ~&hw_q};
    clr_q <= (srst_i | ~clr) ? 6'h00 : clr_q + {5'h00, ~&clr_q};
    gap_q <= srst_i ? 10'h3ff : clr_hit ? 10'h000 : gap_q + {9'h000, ~&gap_q};
    if (srst_i | hw) begin
      ext_en_q <= 1'b0;
      we_en_q  <= 1'b0;
      rdly_q   <= 1'b0;
    end else if (ld) begin
      ext_en_q <= ~|extend_col_strobe_in;
      we_en_q  <= ~extend_col_strobe_in[0] | mode_addr[MB_PIPE];
      rdly_q   <= mode_addr[MB_ROW_DLY];
    end
  end
  col_on_a: assert property (access_request |=> col_strobe)
    else $error("column strobe missed a request");
  col_drop_a: assert property (!access_request && !(|extend_col_strobe_in) |=> !col_strobe)
    else $error("column strobe stayed without cause");
  col_hold_a: assert property (col_strobe && ext_en_q && (&extend_col_strobe_in) |=> col_strobe)
    else $error("column strobe not extended");
  row_fast_a: assert property (grant_go and !rdly_q |=> row_strobe)
    else $error("row strobe not one clock after grant");
  row_slow_a: assert property (grant_go and rdly_q |=> !row_strobe ##1 row_strobe)
    else $error("row strobe not two clocks after grant");
  we_gate_a: assert property (!we_en_q |-> !write_enable_pin)
    else $error("refresh request on write pin while off");
  external_refresh_in_gap_a: assert property ($rose(write_enable_pin) |-> gap_q >= 10'(EXTERNAL_REFRESH_IN_MIN_CYC))
    else $error("refresh request too soon after clear");
  hw_len_a: assert property ($fell(hw) |-> hw_q >= 5'(HW_RST_EDGES))
    else $error("hardware reset held too briefly");
endmodule
`default_nettype wire

//--- bench/tb_dram_ctrl_mode_options.sv
// Testbench joining host end and controller end over the link.
// Assumes software reaches the host through its register port only.
`default_nettype none
module tb_dram_ctrl_mode_options import dmo_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic          mclk_i = 1'b0;
  logic          srst_i = 1'b1;
  logic [3:0]    addr   = 4'h0;
  logic [DW-1:0] wdata  = 8'h00;
  logic [DW-1:0] rdata;
  logic          wr = 1'b0;
  logic          rd = 1'b0;
  int            failures = 0;
  int            n_compared = 0;
  dmo_link_if dmo_link_if_i ();
  wire col = dmo_link_if_i.col_strobe;
  wire row = dmo_link_if_i.row_strobe;
  wire we  = dmo_link_if_i.write_enable_pin;
  wire inrst;
  dmo_dev dmo_dev_i (.mclk_i(mclk_i), .srst_i(srst_i), .lnk(dmo_link_if_i),
    .refresh_request_o(), .in_reset_o(inrst));
  dmo_host dmo_host_i (.mclk_i(mclk_i), .srst_i(srst_i), .lnk(dmo_link_if_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  dmo_monitor dmo_monitor_i (.mclk_i(mclk_i), .srst_i(srst_i),
    .mode_load_strobe(dmo_link_if_i.mode_load_strobe),
    .refresh_disable_in(dmo_link_if_i.refresh_disable_in),
    .external_refresh_in(dmo_link_if_i.external_refresh_in),
    .access_request(dmo_link_if_i.access_request),
    .extend_col_strobe_in(dmo_link_if_i.extend_col_strobe_in),
    .port_b_grant(dmo_link_if_i.port_b_grant), .mode_addr(dmo_link_if_i.mode_addr),
    .col_strobe(col), .row_strobe(row), .write_enable_pin(we));
  // Free-running 40 MHz clock
  always #12.5 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [DW-1:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr    <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Extend bits then mode word, then one load strobe
  task automatic prog(input logic [1:0] ext, input logic [DW-1:0] mode);
    wr_reg(A_DRIVE, {5'h00, ext, 1'b0});
    wr_reg(A_MODE, mode);
    wr_reg(A_CTRL, 8'h02);
    tick(3);
  endtask
  task automatic t_hwrst();
    wr_reg(A_CTRL, 8'h01);
    tick(17);
    #1 chk("reset taken", 16'(inrst), 16'h1);
    tick(7);
    @(posedge mclk_i);
    addr <= A_STAT;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd   <= 1'b0;
    #1 chk("busy after reset", 16'(rdata[0]), 16'h0);
    $display("t_hwrst done");
  endtask
  task automatic t_ext();
    prog(2'b00, 8'h00);
    wr_reg(A_DRIVE, 8'h07);
    wr_reg(A_DRIVE, 8'h06);
    tick(4);
    chk("col held", 16'(col), 16'h1);
    wr_reg(A_DRIVE, 8'h00);
    tick(3);
    chk("col released", 16'(col), 16'h0);
    $display("t_ext done");
  endtask
  task automatic t_row();
    int n[2];
    for (int i = 0; i < 2; i++) begin
      prog(2'b00, DW'(i));
      wr_reg(A_DRIVE, 8'h09);
      n[i] = 0;
      while (row !== 1'b1 && n[i] < 10) begin
        @(posedge mclk_i);
        n[i]++;
      end
      wr_reg(A_DRIVE, 8'h08);
      tick(3);
    end
    chk("row delay step", 16'(n[1]), 16'(n[0] + 1));
    chk("row fast", 16'(n[0]), 16'h2);
    $display("t_row done");
  endtask
  // Off, then on by extend bit with slow rate, then on by pipelining
  task automatic t_we();
    int         n;
    logic [1:0] ext[3] = '{2'b01, 2'b00, 2'b01};
    logic [7:0] md[3]  = '{8'h00, 8'h3c, 8'h02};
    for (int i = 0; i < 3; i++) begin
      prog(ext[i], md[i]);
      wr_reg(A_DRIVE, {3'h0, 1'b1, 1'b0, ext[i], 1'b0});
      tick(25);
      wr_reg(A_DRIVE, {5'h00, ext[i], 1'b0});
      n = 0;
      while (we !== 1'b1 && n < 700) begin
        @(posedge mclk_i);
        n++;
      end
      chk("we pin", 16'(i > 0 ? (n >= EXTERNAL_REFRESH_IN_MIN_CYC - 10 && n <= 605) : n == 700), 16'h1);
    end
    $display("t_we done");
  endtask
  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(4);
    srst_i <= 1'b0;
    t_hwrst();
    t_ext();
    t_row();
    t_we();
    report_and_stop();
  end
  // Watchdog against a hang
  initial begin
    #200us;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
